// >>> inc/isa_cycle_pkg.sv
/*
 * Constants, types and timing for the ISA-side cycle engine.
 * Assumes a 25 MHz system clock; all ISA pins are treated as synchronous.
 */
package isa_cycle_pkg;

    // clock and strobe timing
    localparam int CLK_NS      = 40;
    localparam int CMD_NS      = 160;
    localparam int REC_NS      = 80;
    localparam int CMD_CYC     = (CMD_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC     = (REC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] CMD_LAST = 3'(CMD_CYC - 1);
    localparam logic [2:0] REC_LAST = 3'(REC_CYC - 1);
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE  = 3'h1;

    // bus widths and address split
    localparam int ADDR_W     = 24;
    localparam int LOW_ADDR_W = 20;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int CHAN_N     = 8;
    localparam int IRQ_N      = 16;

    // channels and interrupt lines present on the bus
    localparam logic [CHAN_N-1:0] DMA_CHAN_MASK = 8'hef;
    localparam logic [IRQ_N-1:0]  IRQ_LINES     = 16'hdef8;
    localparam logic [2:0]        WIDE_CHAN_MIN = 3'h5;
    localparam logic [CHAN_N-1:0] CHAN_ONE      = 8'h01;
    localparam logic [CHAN_N-1:0] DACK_IDLE     = 8'hff;
    localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_END
    } cyc_state_t;

    // host cycle request
    typedef struct packed {
        logic              mem;
        logic              wr;
        logic              two_bytes;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } isa_req_t;

    // per-transfer dma setup from the channel controller
    typedef struct packed {
        logic              to_mem;
        logic              last;
        logic [ADDR_W-1:0] addr;
    } dma_ctl_t;

    // read result
    typedef struct packed {
        logic              wide;
        logic [DATA_W-1:0] data;
    } isa_rsp_t;

endpackage

// >>> logic/isa_cycle_engine.sv
/*
 * ISA bus cycle engine: runs host I/O and memory cycles and fly-by DMA
 * cycles on the ISA pins, samples chip selects, interrupts and channel check.
 * Assumes all ISA inputs are synchronous to I_CLK and the data bus wire
 * is resolved outside from O_SD and O_SD_OE.
 */
// Summary of operation
// - 16-bit I/O select widens to sixteen lanes
// - 16-bit memory select widens to sixteen lanes
// - I/O read strobe for slave read
// - I/O write strobe for slave write
// - full-range memory read on every memory read
// - full-range memory write on every memory write
// - address enable marks DMA cycles
// - acknowledge grants channel, starts DMA cycle
// - terminal count on final DMA transfer
// - channel check input sampled as error
// - accept interrupt lines 15,14,12-9,7-3
// - low-range memory strobes only below 1MB
// - latch enable marks valid address
`timescale 1ns/1ps

module isa_cycle_engine
    import isa_cycle_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_ARST_N,
    input  wire logic              I_REQ_VALID,
    input  wire isa_req_t          I_REQ,
    output logic                   O_REQ_READY,
    output logic                   O_DONE,
    output isa_rsp_t               O_RSP,
    input  wire dma_ctl_t          I_DMA,
    output logic                   O_DMA_DONE,
    output logic [ADDR_W-1:0]      O_SA,
    output logic                   O_SBHE_N,
    output logic                   O_BALE,
    input  wire logic [DATA_W-1:0] I_SD,
    output logic [DATA_W-1:0]      O_SD,
    output logic                   O_SD_OE,
    output logic                   O_IOR_N,
    output logic                   O_IOW_N,
    output logic                   O_MEMR_N,
    output logic                   O_MEMW_N,
    output logic                   O_SMEMR_N,
    output logic                   O_SMEMW_N,
    output logic                   O_AEN,
    input  wire logic              I_IOCS16_N,
    input  wire logic              I_MEMCS16_N,
    input  wire logic [CHAN_N-1:0] I_DREQ,
    output logic [CHAN_N-1:0]      O_DACK_N,
    output logic                   O_TC,
    input  wire logic              I_IOCHK_N,
    input  wire logic [IRQ_N-1:0]  I_IRQ,
    output logic [IRQ_N-1:0]       O_IRQ_PENDING,
    output logic                   O_CHAN_ERR
);

    function automatic logic below_1mb(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:LOW_ADDR_W] == '0;
    endfunction

    function automatic logic [2:0] lowest_chan(input logic [CHAN_N-1:0] m);
        logic [2:0] c;
        c = 3'h0;
        for (int i = CHAN_N - 1; i >= 0; i--) begin
            if (m[i]) begin
                c = 3'(i);
            end
        end
        return c;
    endfunction

    cyc_state_t        state_q;
    logic [2:0]        cnt_q;
    isa_req_t          cyc_q;
    dma_ctl_t          dctl_q;
    logic              dma_q;
    logic [2:0]        chan_q;
    logic              wide_q;

    logic [CHAN_N-1:0] dreq_ok;
    logic [2:0]        chan_d;
    logic              take_cpu;
    logic              take_dma;
    logic              to_cmd;
    logic              to_end;
    logic              to_idle;
    logic              rd_cyc;
    logic              wr_cyc;

    // request held until acknowledged, so a level sample suffices
    assign dreq_ok  = I_DREQ & DMA_CHAN_MASK;
    assign chan_d   = lowest_chan(dreq_ok);
    assign take_cpu = (state_q == ST_IDLE) && I_REQ_VALID && O_REQ_READY;
    assign take_dma = (state_q == ST_IDLE) && !I_REQ_VALID && (|dreq_ok);
    assign to_cmd   = (state_q == ST_ADDR);
    assign to_end   = (state_q == ST_CMD) && (cnt_q == CMD_LAST);
    assign to_idle  = (state_q == ST_END) && (cnt_q == REC_LAST);
    assign rd_cyc   = dma_q ? !dctl_q.to_mem : !cyc_q.wr;
    assign wr_cyc   = dma_q ? dctl_q.to_mem : cyc_q.wr;

    // cycle sequencer
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
            cyc_q   <= '0;
            dctl_q  <= '0;
            dma_q   <= 1'b0;
            chan_q  <= 3'h0;
        end else begin
            cnt_q <= cnt_q + CNT_ONE;
            if (take_cpu || take_dma) begin
                state_q <= ST_ADDR;
                cnt_q   <= CNT_ZERO;
                cyc_q   <= I_REQ;
                dctl_q  <= I_DMA;
                dma_q   <= take_dma;
                chan_q  <= chan_d;
            end else if (to_cmd) begin
                state_q <= ST_CMD;
                cnt_q   <= CNT_ZERO;
            end else if (to_end) begin
                state_q <= ST_END;
                cnt_q   <= CNT_ZERO;
            end else if (to_idle) begin
                state_q <= ST_IDLE;
                cnt_q   <= CNT_ZERO;
            end
        end
    end

    // address phase pins
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_SA     <= '0;
            O_SBHE_N <= 1'b1;
            O_BALE   <= 1'b0;
            wide_q   <= 1'b0;
        end else begin
            O_BALE <= take_cpu || take_dma;
            if (take_cpu) begin
                O_SA     <= I_REQ.addr;
                O_SBHE_N <= ~(I_REQ.two_bytes | I_REQ.addr[0]);
            end else if (take_dma) begin
                O_SA     <= I_DMA.addr;
                O_SBHE_N <= (chan_d >= WIDE_CHAN_MIN) ? 1'b0 : ~I_DMA.addr[0];
            end
            if (to_cmd) begin
                if (dma_q) begin
                    wide_q <= chan_q >= WIDE_CHAN_MIN;
                end else if (cyc_q.mem) begin
                    wide_q <= !I_MEMCS16_N;
                end else begin
                    wide_q <= !I_IOCS16_N;
                end
            end
        end
    end

    // command strobes
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_IOR_N   <= 1'b1;
            O_IOW_N   <= 1'b1;
            O_MEMR_N  <= 1'b1;
            O_MEMW_N  <= 1'b1;
            O_SMEMR_N <= 1'b1;
            O_SMEMW_N <= 1'b1;
        end else if (to_cmd) begin
            O_IOR_N   <= !((dma_q || !cyc_q.mem) && wr_cyc == dma_q);
            O_IOW_N   <= !((dma_q || !cyc_q.mem) && rd_cyc == dma_q);
            O_MEMR_N  <= !((dma_q || cyc_q.mem) && rd_cyc);
            O_MEMW_N  <= !((dma_q || cyc_q.mem) && wr_cyc);
            O_SMEMR_N <= !((dma_q || cyc_q.mem) && rd_cyc && below_1mb(O_SA));
            O_SMEMW_N <= !((dma_q || cyc_q.mem) && wr_cyc && below_1mb(O_SA));
        end else if (to_end) begin
            O_IOR_N   <= 1'b1;
            O_IOW_N   <= 1'b1;
            O_MEMR_N  <= 1'b1;
            O_MEMW_N  <= 1'b1;
            O_SMEMR_N <= 1'b1;
            O_SMEMW_N <= 1'b1;
        end
    end

    // dma handshake
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_AEN    <= 1'b0;
            O_DACK_N <= DACK_IDLE;
            O_TC     <= 1'b0;
        end else begin
            if (take_dma) begin
                O_AEN    <= 1'b1;
                O_DACK_N <= ~(CHAN_ONE << chan_d);
            end else if (to_idle) begin
                O_AEN    <= 1'b0;
                O_DACK_N <= DACK_IDLE;
            end
            if (to_cmd) begin
                O_TC <= dma_q && dctl_q.last;
            end else if (to_end) begin
                O_TC <= 1'b0;
            end
        end
    end

    // host data path and handshake
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_REQ_READY <= 1'b1;
            O_DONE      <= 1'b0;
            O_DMA_DONE  <= 1'b0;
            O_RSP       <= '0;
            O_SD        <= '0;
            O_SD_OE     <= 1'b0;
        end else begin
            O_DONE     <= to_idle && !dma_q;
            O_DMA_DONE <= to_idle && dma_q;
            if (take_cpu || take_dma) begin
                O_REQ_READY <= 1'b0;
            end else if (to_idle) begin
                O_REQ_READY <= 1'b1;
            end
            if (take_cpu) begin
                O_SD <= I_REQ.wdata;
            end
            if (to_cmd) begin
                O_SD_OE <= !dma_q && cyc_q.wr;
            end else if (to_idle) begin
                O_SD_OE <= 1'b0;
            end
            if (to_end && !dma_q && !cyc_q.wr) begin
                O_RSP.wide <= wide_q;
                O_RSP.data <= wide_q ? I_SD : {BYTE_ZERO, I_SD[BYTE_W-1:0]};
            end
        end
    end

    // interrupt and error sampling
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_IRQ_PENDING <= '0;
            O_CHAN_ERR    <= 1'b0;
        end else begin
            O_IRQ_PENDING <= I_IRQ & IRQ_LINES;
            O_CHAN_ERR    <= !I_IOCHK_N;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    property p_io16_wide;
        (state_q == ST_ADDR && !dma_q && !cyc_q.mem && !I_IOCS16_N) |=> wide_q;
    endproperty
    a_io16_wide: assert property (p_io16_wide) else $error("io16 not widened");

    property p_mem16_wide;
        (state_q == ST_ADDR && !dma_q && cyc_q.mem && I_MEMCS16_N) |=> !wide_q;
    endproperty
    a_mem16_wide: assert property (p_mem16_wide) else $error("mem8 widened");

    property p_ior_read;
        $fell(O_IOR_N) |-> (state_q == ST_CMD) && (dma_q ? dctl_q.to_mem : !cyc_q.wr);
    endproperty
    a_ior_read: assert property (p_ior_read) else $error("ior on wrong cycle");

    property p_iow_width;
        $fell(O_IOW_N) |-> !O_IOW_N [*4] ##1 O_IOW_N;
    endproperty
    a_iow_width: assert property (p_iow_width) else $error("iow width wrong");

    property p_memr_all;
        (state_q == ST_ADDR && !dma_q && cyc_q.mem && !cyc_q.wr) |=> !O_MEMR_N;
    endproperty
    a_memr_all: assert property (p_memr_all) else $error("memr missing");

    property p_memw_all;
        (state_q == ST_ADDR && dma_q && dctl_q.to_mem) |=> !O_MEMW_N && !O_IOR_N;
    endproperty
    a_memw_all: assert property (p_memw_all) else $error("dma memw missing");

    property p_aen_dma;
        $rose(O_AEN) |-> O_BALE && O_DACK_N != DACK_IDLE ##1 O_AEN [*5];
    endproperty
    a_aen_dma: assert property (p_aen_dma) else $error("aen not held");

    property p_dack_grant;
        take_dma |-> I_DREQ[chan_d] ##1 O_DACK_N[chan_q] == 1'b0;
    endproperty
    a_dack_grant: assert property (p_dack_grant) else $error("dack wrong channel");

    property p_tc_last;
        O_TC |-> !O_AEN ? 1'b0 : (dctl_q.last && state_q == ST_CMD);
    endproperty
    a_tc_last: assert property (p_tc_last) else $error("tc outside last dma");

    property p_chk_err;
        !I_IOCHK_N |=> O_CHAN_ERR;
    endproperty
    a_chk_err: assert property (p_chk_err) else $error("channel check lost");

    property p_irq_lines;
        (O_IRQ_PENDING & ~IRQ_LINES) == '0;
    endproperty
    a_irq_lines: assert property (p_irq_lines) else $error("absent irq reported");

    property p_smemr_low;
        !O_SMEMR_N |-> !O_MEMR_N && below_1mb(O_SA);
    endproperty
    a_smemr_low: assert property (p_smemr_low) else $error("smemr above 1mb");

    property p_bale_addr;
        O_BALE |-> state_q == ST_ADDR ##1 !O_BALE;
    endproperty
    a_bale_addr: assert property (p_bale_addr) else $error("bale misplaced");

    property p_one_dack;
        $onehot0(~O_DACK_N);
    endproperty
    a_one_dack: assert property (p_one_dack) else $error("multiple dack");

    c_io_read:  cover property (take_cpu && !I_REQ.mem && !I_REQ.wr);
    c_mem_wr:   cover property (take_cpu && I_REQ.mem && I_REQ.wr);
    c_dma_tc:   cover property (O_TC && !O_MEMW_N);
    c_wide_rd:  cover property (O_DONE && O_RSP.wide);

endmodule // isa_cycle_engine

// >>> tb/isa_far_side.sv
/*
 * Model of the cards on the far side of the ISA pins: one I/O and one
 * memory slave with 16-bit decodes, and DMA devices on every channel.
 * Assumes the bench resolves the data wire and drives the control inputs.
 */
`timescale 1ns/1ps

module isa_far_side
    import isa_cycle_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire logic [ADDR_W-1:0] i_sa,
    input  wire logic              i_rd_n,
    input  wire logic              i_aen,
    input  wire logic [CHAN_N-1:0] i_dack_n,
    input  wire logic              i_io16,
    input  wire logic              i_mem16,
    input  wire logic [DATA_W-1:0] i_rd_val,
    input  wire logic [CHAN_N-1:0] i_dreq_set,
    output logic [DATA_W-1:0]      o_sd,
    output logic                   o_iocs16_n,
    output logic                   o_memcs16_n,
    output logic [CHAN_N-1:0]      o_dreq
);
    assign o_iocs16_n = ~(i_io16 & ~i_aen & (i_sa[15:8] == 8'h03));
    assign o_memcs16_n = ~(i_mem16 & (i_sa[23:17] == 7'h08));
    // released bus shows inverted data
    assign o_sd = i_rd_n ? ~i_rd_val : i_rd_val;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dreq <= 8'h00;
        end else begin
            o_dreq <= (o_dreq | i_dreq_set) & i_dack_n;
        end
    end
endmodule // isa_far_side

// >>> tb/isa_bus_cycle_dma_signalling_tb.sv
/*
 * Self-checking bench for the ISA cycle engine: host I/O and memory
 * cycles, DMA grants, interrupt and channel check sampling.
 * Assumes the far-side model and a 25 MHz clock.
 */
`timescale 1ns/1ps

module isa_bus_cycle_dma_signalling_tb;
    import isa_cycle_pkg::*;

    logic              clk, arst_n, req_valid, req_ready, done, dma_done;
    logic              bale, sbhe_n, sd_oe, aen, tc, chan_err, iochk_n, rd_n;
    logic              ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n;
    logic              io16, mem16, iocs16_n, memcs16_n, sbhe_at;
    isa_req_t          req;
    isa_rsp_t          rsp;
    dma_ctl_t          dma;
    logic [ADDR_W-1:0] sa, sa_at;
    logic [DATA_W-1:0] sd_out, sd_far, sd_wire, rd_val, sd_seen;
    logic [CHAN_N-1:0] dreq, dack_n, dreq_set, ack;
    logic [IRQ_N-1:0]  irq, irq_pend;
    logic [5:0]        stb;
    logic [23:0]       cntv;
    int                n_errors, n_tests, n_aen, n_tc, n_oe, n_bale, done_at;

    assign rd_n = ior_n & memr_n;
    assign sd_wire = sd_oe ? sd_out : sd_far;
    assign stb = ~{smemw_n, smemr_n, memw_n, memr_n, iow_n, ior_n};

    isa_cycle_engine u_dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_REQ_VALID(req_valid),
        .I_REQ(req), .O_REQ_READY(req_ready), .O_DONE(done), .O_RSP(rsp), .I_DMA(dma),
        .O_DMA_DONE(dma_done), .O_SA(sa), .O_SBHE_N(sbhe_n), .O_BALE(bale),
        .I_SD(sd_wire), .O_SD(sd_out), .O_SD_OE(sd_oe), .O_IOR_N(ior_n), .O_IOW_N(iow_n),
        .O_MEMR_N(memr_n), .O_MEMW_N(memw_n), .O_SMEMR_N(smemr_n), .O_SMEMW_N(smemw_n),
        .O_AEN(aen), .I_IOCS16_N(iocs16_n), .I_MEMCS16_N(memcs16_n), .I_DREQ(dreq),
        .O_DACK_N(dack_n), .O_TC(tc), .I_IOCHK_N(iochk_n), .I_IRQ(irq),
        .O_IRQ_PENDING(irq_pend), .O_CHAN_ERR(chan_err));

    isa_far_side u_far (.i_clk(clk), .i_arst_n(arst_n), .i_sa(sa), .i_rd_n(rd_n),
        .i_aen(aen), .i_dack_n(dack_n), .i_io16(io16), .i_mem16(mem16),
        .i_rd_val(rd_val), .i_dreq_set(dreq_set), .o_sd(sd_far),
        .o_iocs16_n(iocs16_n), .o_memcs16_n(memcs16_n), .o_dreq(dreq));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // gathers strobe, enable and acknowledge activity until a done pulse
    task automatic watch(input logic for_dma);
        int i, j;
        cntv = '0;
        ack = '0;
        n_aen = 0;
        n_tc = 0;
        n_oe = 0;
        n_bale = 0;
        done_at = 0;
        for (i = 1; i < 24 && done_at == 0; i++) begin
            @(negedge clk);
            for (j = 0; j < 6; j++) if (stb[j] === 1'b1) cntv[j*4 +: 4] += 4'h1;
            if (aen === 1'b1) n_aen++;
            if (tc === 1'b1) n_tc++;
            if (bale === 1'b1) begin
                n_bale++;
                sbhe_at = sbhe_n;
                sa_at = sa;
            end
            if (sd_oe === 1'b1) begin
                n_oe++;
                sd_seen = sd_out;
            end
            chk(32'($countones(~dack_n) <= 1), 1);
            ack |= ~dack_n;
            if ((for_dma ? dma_done : done) === 1'b1) done_at = i;
        end
        if (done_at == 0) begin
            n_errors++;
            complete_run();
        end
    endtask

    task automatic host(input logic m, w, t, input logic [23:0] a, input logic [15:0] d);
        int k;
        for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clk);
        if (req_ready !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{mem: m, wr: w, two_bytes: t, addr: a, wdata: d};
        @(posedge clk);
        req_valid <= 1'b0;
        watch(1'b0);
        chk(done_at, 8);
        chk(n_bale, 1);
        chk(sa_at, a);
        chk(n_aen, 0);
    endtask

    task automatic sc_io_read();
        @(posedge clk);
        io16 <= 1'b0;
        rd_val <= 16'ha5c3;
        host(1'b0, 1'b0, 1'b0, 24'h000310, 16'h0000);
        chk(cntv, 24'h000004);
        chk(sbhe_at, 1);
        chk(rsp, {1'b0, 16'h00c3});
        @(posedge clk);
        io16 <= 1'b1;
        rd_val <= 16'h5a3c;
        host(1'b0, 1'b0, 1'b1, 24'h000302, 16'h0000);
        chk(sbhe_at, 0);
        chk(rsp, {1'b1, 16'h5a3c});
    endtask

    task automatic sc_io_write();
        host(1'b0, 1'b1, 1'b0, 24'h000301, 16'hbeef);
        chk(cntv, 24'h000040);
        chk(n_oe, 6);
        chk(sd_seen, 16'hbeef);
        chk(sbhe_at, 0);
    endtask

    task automatic sc_mem();
        @(posedge clk);
        mem16 <= 1'b0;
        rd_val <= 16'h9e71;
        host(1'b1, 1'b0, 1'b0, 24'h0c8000, 16'h0000);
        chk(cntv, 24'h040400);
        chk(rsp, {1'b0, 16'h0071});
        @(posedge clk);
        mem16 <= 1'b1;
        host(1'b1, 1'b0, 1'b1, 24'h100000, 16'h0000);
        chk(cntv, 24'h000400);
        chk(rsp, {1'b1, 16'h9e71});
        host(1'b1, 1'b1, 1'b1, 24'h100002, 16'h1234);
        chk(cntv, 24'h004000);
        chk(sd_seen, 16'h1234);
    endtask

    task automatic sc_dma();
        @(posedge clk);
        dma <= '{to_mem: 1'b1, last: 1'b1, addr: 24'h002000};
        dreq_set <= 8'h42;
        @(posedge clk);
        dreq_set <= 8'h00;
        watch(1'b1);
        chk(ack, 8'h02);
        chk(cntv, 24'h404004);
        chk(n_aen, 7);
        chk(n_tc, 4);
        chk(n_oe, 0);
        chk(sbhe_at, 1);
        chk(sa_at, 24'h002000);
        watch(1'b1);
        chk(ack, 8'h40);
        chk(sbhe_at, 0);
        @(posedge clk);
        dma <= '{to_mem: 1'b0, last: 1'b0, addr: 24'h120000};
        dreq_set <= 8'h01;
        @(posedge clk);
        dreq_set <= 8'h00;
        watch(1'b1);
        chk(ack, 8'h01);
        chk(cntv, 24'h000440);
        chk(n_tc, 0);
    endtask

    task automatic sc_side();
        @(posedge clk);
        irq <= 16'hffff;
        iochk_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(irq_pend, 16'hdef8);
        chk(chan_err, 1);
        @(posedge clk);
        irq <= 16'h0421;
        iochk_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(irq_pend, 16'h0420);
        chk(chan_err, 0);
    endtask

    initial begin
        n_errors = 0;
        n_tests = 0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        dma = '0;
        iochk_n = 1'b1;
        irq = '0;
        io16 = 1'b0;
        mem16 = 1'b0;
        rd_val = '0;
        dreq_set = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        sc_io_read();
        sc_io_write();
        sc_mem();
        sc_dma();
        sc_side();
        complete_run();
    end
endmodule // isa_bus_cycle_dma_signalling_tb
